// file: src/iacid_bank.v
// Purpose: identification bank for instruction set and level one cache; only the cache select is writable
// Assumes: one coprocessor move request per cycle, pulse cp_req, same clock as core
// Notes: answer follows one cycle after the request, all outputs registered
`include "iacid_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module iacid_bank #(
	parameter CACHE_KB = 32,
	parameter [31:0] ISA_ATTR_ONE = 32'h00000000,
	parameter [31:0] ISA_ATTR_TWO = 32'h00000000,
	parameter [31:0] ISA_ATTR_THREE = 32'h00000000,
	parameter [31:0] ISA_ATTR_FOUR = 32'h00000000,
	parameter [3:0] ISA_ZERO_SWAP = 4'h0
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	// Coprocessor move request
	input wire cp_req,
	input wire cp_read,
	input wire [2:0] cp_opc1,
	input wire [3:0] cp_crn,
	input wire [3:0] cp_crm,
	input wire [2:0] cp_opc2,
	input wire [31:0] cp_wdata,
	input wire cp_privileged,
	input wire cp_secure,
	// Answer
	output reg cp_ack,
	output reg cp_undef,
	output reg [31:0] cp_rdata,
	// Current selection, for the cache logic
	output reg instr_or_data_select
);

	// Packs the coprocessor fields into one access key
	function [`IACID_KEY_W-1:0] access_key;
		input [2:0] opc1;
		input [3:0] crn;
		input [3:0] crm;
		input [2:0] opc2;
		begin
			access_key = {opc1, crn, crm, opc2};
		end
	endfunction

	// Set count from configured size; unsupported sizes fall back to 32KB
	function [14:0] set_count_of;
		input integer kb;
		begin
			case (kb)
				16: set_count_of = `IACID_SETS_16K;
				64: set_count_of = `IACID_SETS_64K;
				default: set_count_of = `IACID_SETS_32K;
			endcase
		end
	endfunction

	// Builds one geometry word; both caches share every field but the flags
	function [31:0] geometry_word;
		input [3:0] flags;
		input [14:0] sets;
		input [9:0] ways;
		input [2:0] line;
		begin
			geometry_word = {flags, sets, ways, line};
		end
	endfunction

	// True for every key that names a read-only identification register
	function is_id_key;
		input [`IACID_KEY_W-1:0] k;
		begin
			case (k)
				`IACID_KEY_ISA1, `IACID_KEY_ISA2, `IACID_KEY_ISA3, `IACID_KEY_ISA4: is_id_key = 1'b1;
				`IACID_KEY_ISA5, `IACID_KEY_ISA6, `IACID_KEY_ISA7: is_id_key = 1'b1;
				`IACID_KEY_GEOM, `IACID_KEY_HIER: is_id_key = 1'b1;
				default: is_id_key = 1'b0;
			endcase
		end
	endfunction

	// Packs the four capability flags in their fixed order, top bit first
	function [3:0] flag_nibble;
		input write_through;
		input write_back;
		input read_alloc;
		input write_alloc;
		begin
			flag_nibble = {write_through, write_back, read_alloc, write_alloc};
		end
	endfunction

	wire [`IACID_KEY_W-1:0] key;
	wire [14:0] set_count_field;
	wire [9:0] way_count_field;
	wire [2:0] line_length_field;
	wire [3:0] data_flags;
	wire [3:0] instr_flags;
	wire [3:0] data_flag_word;
	wire [3:0] instr_flag_word;
	wire data_write_through_flag;
	wire data_write_back_flag;
	wire data_read_alloc_flag;
	wire data_write_alloc_flag;
	wire instr_write_through_flag;
	wire instr_write_back_flag;
	wire instr_read_alloc_flag;
	wire instr_write_alloc_flag;
	wire [31:0] cache_geometry_data;
	wire [31:0] cache_geometry_instr;
	wire [2:0] unification_level;
	wire [2:0] coherence_level;
	wire [2:0] inner_share_unify_level;
	wire [2:0] level_one_cache_type;
	wire [17:0] upper_level_types;
	// Levels two to seven hold no cache
	wire [2:0] level_two_cache_type;
	wire [2:0] level_three_cache_type;
	wire [2:0] level_four_cache_type;
	wire [2:0] level_five_cache_type;
	wire [2:0] level_six_cache_type;
	wire [2:0] level_seven_cache_type;
	wire [31:0] cache_hierarchy_id;
	wire [3:0] swap_fraction_field;
	wire [31:0] isa_attr_four;
	wire selected_instr;
	wire [31:0] cache_select_view;

	// Selection is banked per security state
	reg select_secure;
	reg select_nonsecure;

	reg next_ack;
	reg next_undef;
	reg [31:0] next_rdata;
	reg next_select_secure;
	reg next_select_nonsecure;

	assign key = access_key(cp_opc1, cp_crn, cp_crm, cp_opc2);

	// Geometry fields are shared by both caches except the capability flags
	assign set_count_field = set_count_of(CACHE_KB);
	assign way_count_field = `IACID_WAYS_FOUR;
	assign line_length_field = `IACID_LINE_EIGHT;
	// Each capability is named so that the cache logic can take single bits
	assign data_flag_word = `IACID_FLAGS_DATA;
	assign data_write_through_flag = data_flag_word[3];
	assign data_write_back_flag = data_flag_word[2];
	assign data_read_alloc_flag = data_flag_word[1];
	assign data_write_alloc_flag = data_flag_word[0];
	assign instr_flag_word = `IACID_FLAGS_INSTR;
	assign instr_write_through_flag = instr_flag_word[3];
	assign instr_write_back_flag = instr_flag_word[2];
	assign instr_read_alloc_flag = instr_flag_word[1];
	assign instr_write_alloc_flag = instr_flag_word[0];
	assign data_flags = flag_nibble(data_write_through_flag, data_write_back_flag, data_read_alloc_flag,
		data_write_alloc_flag);
	assign instr_flags = flag_nibble(instr_write_through_flag, instr_write_back_flag, instr_read_alloc_flag,
		instr_write_alloc_flag);
	// Flags sit in bits 31 to 28: through, back, read alloc, write alloc
	assign cache_geometry_data = geometry_word(data_flags, set_count_field, way_count_field,
		line_length_field);
	assign cache_geometry_instr = geometry_word(instr_flags, set_count_field, way_count_field,
		line_length_field);

	assign unification_level = `IACID_LEVEL_ONE;
	assign coherence_level = `IACID_LEVEL_ONE;
	assign inner_share_unify_level = `IACID_LEVEL_ONE;
	assign level_one_cache_type = `IACID_CTYPE_SPLIT;
	assign level_two_cache_type = `IACID_CTYPE_NONE;
	assign level_three_cache_type = `IACID_CTYPE_NONE;
	assign level_four_cache_type = `IACID_CTYPE_NONE;
	assign level_five_cache_type = `IACID_CTYPE_NONE;
	assign level_six_cache_type = `IACID_CTYPE_NONE;
	assign level_seven_cache_type = `IACID_CTYPE_NONE;
	// Highest level sits in the top bits of the group
	assign upper_level_types = {level_seven_cache_type, level_six_cache_type, level_five_cache_type,
		level_four_cache_type, level_three_cache_type, level_two_cache_type};
	// Bits 31 and 30 are unpredictable; they read as zero here
	assign cache_hierarchy_id = {2'h0, unification_level, coherence_level, inner_share_unify_level,
		upper_level_types, level_one_cache_type};

	// Swap fraction is hidden unless attribute zero reports no swap support,
	// so software that forgets the dependency still sees nothing misleading
	assign swap_fraction_field = (ISA_ZERO_SWAP == 4'h0) ?
		ISA_ATTR_FOUR[`IACID_SWFRAC_MSB:`IACID_SWFRAC_LSB] : 4'h0;
	assign isa_attr_four = {swap_fraction_field, ISA_ATTR_FOUR[`IACID_SWFRAC_LSB-1:0]};

	// The selection seen by the geometry read is that of the requesting state
	assign selected_instr = cp_secure ? select_secure : select_nonsecure;
	// Level field and upper bits always read zero
	assign cache_select_view = {31'h00000000, selected_instr};

	always @* begin
		next_ack = cp_req;
		next_undef = 1'b0;
		next_rdata = 32'h00000000;
		next_select_secure = select_secure;
		next_select_nonsecure = select_nonsecure;
		if (cp_req) begin
			if (!cp_privileged) begin
				// No contents leak to user mode
				next_undef = 1'b1;
			end else begin
				// Identification reads ignore the security state, except geometry, which follows that state's selection
				case (key)
					`IACID_KEY_ISA1: begin
						if (cp_read) begin
							next_rdata = ISA_ATTR_ONE;
						end
					end
					`IACID_KEY_ISA2: begin
						if (cp_read) begin
							next_rdata = ISA_ATTR_TWO;
						end
					end
					`IACID_KEY_ISA3: begin
						if (cp_read) begin
							next_rdata = ISA_ATTR_THREE;
						end
					end
					`IACID_KEY_ISA4: begin
						if (cp_read) begin
							next_rdata = isa_attr_four;
						end
					end
					`IACID_KEY_ISA5, `IACID_KEY_ISA6, `IACID_KEY_ISA7: begin
						next_rdata = `IACID_RESERVED_WORD;
					end
					`IACID_KEY_GEOM: begin
						if (cp_read) begin
							next_rdata = selected_instr ? cache_geometry_instr : cache_geometry_data;
						end
					end
					`IACID_KEY_HIER: begin
						if (cp_read) begin
							next_rdata = cache_hierarchy_id;
						end
					end
					`IACID_KEY_SEL: begin
						if (cp_read) begin
							next_rdata = cache_select_view;
						end else if (cp_secure) begin
							// Only bit zero is stored; level bits are dropped
							next_select_secure = cp_wdata[`IACID_SEL_IND_BIT];
						end else begin
							next_select_nonsecure = cp_wdata[`IACID_SEL_IND_BIT];
						end
					end
					default: begin
						next_undef = 1'b1;
					end
				endcase
				// Writes to identification keys fall through the case unchanged
				// and are answered without effect
				if (!cp_read && is_id_key(key)) begin
					next_rdata = 32'h00000000;
				end
			end
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			cp_ack <= 1'b0;
			cp_undef <= 1'b0;
			cp_rdata <= 32'h00000000;
			select_secure <= `IACID_SEL_RESET;
			select_nonsecure <= `IACID_SEL_RESET;
			instr_or_data_select <= `IACID_SEL_RESET;
		end else begin
			cp_ack <= next_ack;
			cp_undef <= next_undef;
			cp_rdata <= next_rdata;
			select_secure <= next_select_secure;
			select_nonsecure <= next_select_nonsecure;
			// Exported selection follows the secure copy
			instr_or_data_select <= next_select_secure;
		end
	end

endmodule // iacid_bank

`default_nettype wire

// file: src/iacid_regs.vh
// Purpose: constants for the identification register bank
// Assumes: access keys pack {opc1[2:0], crn[3:0], crm[3:0], opc2[2:0]}
// Notes: all values are fixed by implementation
`ifndef IACID_REGS_VH
`define IACID_REGS_VH

// Coprocessor access keys
`define IACID_KEY_W 14
`define IACID_KEY_ISA1 14'h0011
`define IACID_KEY_ISA2 14'h0012
`define IACID_KEY_ISA3 14'h0013
`define IACID_KEY_ISA4 14'h0014
`define IACID_KEY_ISA5 14'h0015
`define IACID_KEY_ISA6 14'h0016
`define IACID_KEY_ISA7 14'h0017
`define IACID_KEY_GEOM 14'h0800
`define IACID_KEY_HIER 14'h0801
`define IACID_KEY_SEL 14'h1000

// Geometry fields
`define IACID_FLAGS_MSB 31
`define IACID_FLAGS_LSB 28
`define IACID_SETS_MSB 27
`define IACID_SETS_LSB 13
`define IACID_WAYS_MSB 12
`define IACID_WAYS_LSB 3
`define IACID_LINE_MSB 2
`define IACID_LINE_LSB 0
`define IACID_FLAGS_DATA 4'h7
`define IACID_FLAGS_INSTR 4'h2
`define IACID_SETS_16K 15'h007F
`define IACID_SETS_32K 15'h00FF
`define IACID_SETS_64K 15'h01FF
`define IACID_WAYS_FOUR 10'h003
`define IACID_LINE_EIGHT 3'h1

// Hierarchy fields
`define IACID_LOU_LSB 27
`define IACID_LOC_LSB 24
`define IACID_INNER_SHARE_UNIFY_LEVEL_LSB 21
`define IACID_LEVEL_ONE 3'h1
`define IACID_CTYPE_SPLIT 3'h3
`define IACID_CTYPE_NONE 3'h0

// Cache select register
`define IACID_SEL_IND_BIT 0
`define IACID_SEL_RESET 1'h0
`define IACID_RESERVED_WORD 32'h00000000

// Swap field position in attribute registers zero and four
`define IACID_SWAP_MSB 3
`define IACID_SWAP_LSB 0
`define IACID_SWFRAC_MSB 31
`define IACID_SWFRAC_LSB 28

`endif

// file: tb/iacid_bank_props.sv
// Purpose: assertions on the identification bank ports
// Assumes: bank built with its default 32KB cache size
// Notes: bound to every instance of the bank
`include "iacid_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module iacid_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Request
	input wire logic cp_req,
	input wire logic cp_read,
	input wire logic [2:0] cp_opc1,
	input wire logic [3:0] cp_crn,
	input wire logic [3:0] cp_crm,
	input wire logic [2:0] cp_opc2,
	input wire logic [31:0] cp_wdata,
	input wire logic cp_privileged,
	input wire logic cp_secure,
	// Answer
	input wire logic cp_ack,
	input wire logic cp_undef,
	input wire logic [31:0] cp_rdata,
	input wire logic instr_or_data_select
);
	wire [13:0] key = {cp_opc1, cp_crn, cp_crm, cp_opc2};
	wire pr = cp_req && cp_privileged && cp_read;
	wire wr = cp_req && cp_privileged && !cp_read;
	// Only the secure copy of the select is visible here
	wire geo = pr && key == `IACID_KEY_GEOM && cp_secure;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_unpriv_hidden: assert property (cp_req && !cp_privileged |=> cp_undef && cp_rdata == 32'h00000000)
		else $error("unprivileged access returned data");
	a_reserved_zero: assert property (pr && key >= `IACID_KEY_ISA5 && key <= `IACID_KEY_ISA7 |=> !cp_undef && cp_rdata == 32'h0)
		else $error("reserved attribute slot not zero");
	a_data_flags: assert property (geo && !instr_or_data_select |=> cp_rdata[31:28] == 4'h7)
		else $error("data cache flags wrong");
	a_instr_flags: assert property (geo && instr_or_data_select |=> cp_rdata[31:28] == 4'h2)
		else $error("instruction cache flags wrong");
	a_geom_fields: assert property (pr && key == `IACID_KEY_GEOM |=> cp_rdata[27:0] == 28'h01FE019)
		else $error("geometry fields wrong");
	a_hier_value: assert property (pr && key == `IACID_KEY_HIER |=> cp_rdata == 32'h09200003)
		else $error("hierarchy value wrong");
	a_attr_served: assert property (pr && key >= `IACID_KEY_ISA1 && key <= `IACID_KEY_ISA4 |=> cp_ack && !cp_undef)
		else $error("attribute read not served");
	a_id_write_quiet: assert property (wr && key != `IACID_KEY_SEL |=> cp_ack && cp_rdata == 32'h0 && $stable(instr_or_data_select))
		else $error("write to identification changed state");
	a_select_tracks: assert property (wr && cp_secure && key == `IACID_KEY_SEL |=> instr_or_data_select == $past(cp_wdata[0]))
		else $error("select bit not taken");
	c_geom_read: cover property (geo ##1 cp_ack);
	c_unpriv: cover property (cp_req && !cp_privileged);
	c_select_write: cover property (wr && key == `IACID_KEY_SEL);
endmodule // iacid_props
bind iacid_bank iacid_props i_props (.sys_clk(sys_clk), .reset(reset), .cp_req(cp_req), .cp_read(cp_read),
	.cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_wdata(cp_wdata),
	.cp_privileged(cp_privileged), .cp_secure(cp_secure), .cp_ack(cp_ack), .cp_undef(cp_undef),
	.cp_rdata(cp_rdata), .instr_or_data_select(instr_or_data_select));
`default_nettype wire

// file: tb/iacid_bank_tb.sv
// Purpose: self-checking bench for the identification bank
// Assumes: one request every other cycle, answer one cycle later
// Notes: attribute values are arbitrary test patterns
`include "iacid_regs.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module iacid_bank_tb;
	logic sys_clk = 0, reset = 1, cp_req = 0, cp_read = 0, cp_privileged = 0, cp_secure = 0;
	logic [13:0] key = 14'h0000;
	logic [31:0] cp_wdata = 32'h0, cp_rdata;
	logic cp_ack, cp_undef, instr_or_data_select;
	int n_mismatch = 0, compares = 0;
	logic [31:0] isa [1:4] = '{32'h11111111, 32'h22222222, 32'h33333333, 32'hF4444444};
	iacid_bank #(.ISA_ATTR_ONE(32'h11111111), .ISA_ATTR_TWO(32'h22222222), .ISA_ATTR_THREE(32'h33333333),
		.ISA_ATTR_FOUR(32'hF4444444)) i_dut (.sys_clk(sys_clk), .reset(reset), .cp_req(cp_req),
		.cp_read(cp_read), .cp_opc1(key[13:11]), .cp_crn(key[10:7]), .cp_crm(key[6:3]), .cp_opc2(key[2:0]),
		.cp_wdata(cp_wdata), .cp_privileged(cp_privileged), .cp_secure(cp_secure), .cp_ack(cp_ack),
		.cp_undef(cp_undef), .cp_rdata(cp_rdata), .instr_or_data_select(instr_or_data_select));
	task access(input logic [13:0] k, input logic rd, input logic pr, input logic sc, input logic [31:0] wd,
		input logic [31:0] exp, input logic ex_u, input string nm);
		@(posedge sys_clk);
		key <= k;
		cp_read <= rd;
		cp_privileged <= pr;
		cp_secure <= sc;
		cp_wdata <= wd;
		cp_req <= 1'b1;
		@(posedge sys_clk);
		cp_req <= 1'b0;
		#1;
		`CHK(nm, {1'b1, ex_u, exp}, {cp_ack, cp_undef, cp_rdata})
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial forever #2.5 sys_clk = ~sys_clk;
	// Whole run is about 60 cycles, so this only trips on a hang
	initial begin
		repeat (2000) @(posedge sys_clk);
		n_mismatch++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		`CHK("select after reset", 1'b0, instr_or_data_select)
		for (int i = 1; i <= 4; i++) begin
			access(14'(`IACID_KEY_ISA1 + i - 1), 1, 1, i[0], 0, isa[i], 0, "attr read");
		end
		for (int i = 5; i <= 7; i++) begin
			access(14'(`IACID_KEY_ISA1 + i - 1), 1, 1, 1, 0, 32'h0, 0, "reserved");
		end
		access(`IACID_KEY_HIER, 1, 1, 0, 0, 32'h09200003, 0, "hierarchy");
		access(`IACID_KEY_GEOM, 1, 1, 1, 0, 32'h701FE019, 0, "geometry data");
		$display("test id reads done");
		access(`IACID_KEY_SEL, 0, 1, 1, 32'hFFFFFFFF, 32'h0, 0, "select write");
		access(`IACID_KEY_SEL, 1, 1, 1, 0, 32'h1, 0, "select read");
		access(`IACID_KEY_GEOM, 1, 1, 1, 0, 32'h201FE019, 0, "geometry instr");
		access(`IACID_KEY_GEOM, 1, 1, 0, 0, 32'h701FE019, 0, "geometry other state");
		`CHK("exported select", 1'b1, instr_or_data_select)
		access(`IACID_KEY_SEL, 0, 1, 0, 32'h00000001, 32'h0, 0, "select write other state");
		access(`IACID_KEY_GEOM, 1, 1, 0, 0, 32'h201FE019, 0, "geometry other instr");
		access(`IACID_KEY_SEL, 0, 0, 0, 32'h0, 32'h0, 1, "unprivileged select write");
		access(`IACID_KEY_SEL, 1, 1, 0, 0, 32'h1, 0, "select other kept");
		access(`IACID_KEY_SEL, 1, 1, 1, 0, 32'h1, 0, "select secure kept");
		$display("test select done");
		access(`IACID_KEY_GEOM, 0, 1, 1, 32'hFFFFFFFF, 32'h0, 0, "id write");
		access(`IACID_KEY_ISA1, 0, 1, 1, 32'h0, 32'h0, 0, "attr write");
		access(`IACID_KEY_GEOM, 1, 1, 1, 0, 32'h201FE019, 0, "geometry kept");
		access(`IACID_KEY_ISA1, 1, 1, 1, 0, isa[1], 0, "attr kept");
		access(`IACID_KEY_HIER, 1, 0, 1, 0, 32'h0, 1, "unprivileged");
		$display("test protection done");
		print_verdict;
	end
endmodule // iacid_bank_tb
`default_nettype wire
